// ===== design/motor_pwm_time_base.sv
// Purpose: motor pwm time base with axi4-lite registers and four duty generators
// Assumes: aclk at 40 MHz is the instruction clock, cpu_idle is synchronous
// Notes: status bits are write-one-to-clear, set wins over clear
//
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps

// How it works
// - counter runs only while the run bit of control is set
// - idle halt bit set stops the time base while the cpu idles
// - four-bit postscaler divides time base events from 1:1 up to 1:16
// - two-bit prescaler; code 11 makes one count last 64 clocks
// - mode 00 counts up repeatedly while enabled
// - mode 01 runs one period then clears the run bit
// - modes 10 and 11 count up/down; 11 also interrupts at zero and at top
// - count register bit 15 reads direction, one while counting down
// - count register low 15 bits hold live count, readable and writable
// - period register holds 15-bit period; top bit reads zero
// - four duty generators drive four high/low output pairs
// - complementary low output is inverse of its high output
// - software picks immediate or boundary-synchronised duty updates
module motor_pwm_time_base
  import pwm_tb_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [pwm_tb_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pwm_tb_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cpu_idle,
  output logic [pwm_tb_pkg::N_GEN-1:0] high_out,
  output logic [pwm_tb_pkg::N_GEN-1:0] low_out,
  output logic irq
);
  import pwm_tb_pkg::*;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic known(input logic [ADDR_W-1:0] a);
    known = (a <= OFF_MASK) && (a[1:0] == 2'h0);
  endfunction

  logic [15:0] control_q, control_d;
  logic [14:0] count_q, count_d;
  logic dir_q, dir_d;
  logic [14:0] period_q, period_d;
  logic [15:0] duty_q [N_GEN];
  logic [15:0] duty_d [N_GEN];
  logic [1:0] misc_q, misc_d;
  logic [N_STATUS-1:0] status_q, status_d, mask_q, mask_d;
  logic [5:0] pre_q, pre_d;
  logic [3:0] post_q, post_d;
  logic aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
  logic [ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;

  logic do_write, run, step, at_top, at_zero, period_end, event_raw, event_out;
  logic [5:0] pre_limit;
  count_mode_t mode;
  logic [N_STATUS-1:0] set_bits;
  logic [15:0] count_wr, period_wr;

  tick_if tick ();

  assign mode = count_mode_t'(control_q[POS_MODE +: 2]);
  assign do_write = aw_q && w_q && !b_q;
  assign count_wr = merge16({1'b0, count_q}, wdata_q, wstrb_q);
  assign period_wr = merge16({1'b0, period_q}, wdata_q, wstrb_q);
  assign run = control_q[BIT_RUN] && !(control_q[BIT_IDLE_HALT] && cpu_idle);

  always_comb
  begin
    unique case (control_q[POS_PRESCALE +: 2])
      2'h0: pre_limit = 6'h00;
      2'h1: pre_limit = 6'h03;
      2'h2: pre_limit = 6'h0F;
      2'h3: pre_limit = 6'h3F;
    endcase
  end

  assign step = run && (pre_q >= pre_limit);
  assign at_top = (count_q >= period_q);
  assign at_zero = (count_q == 15'h0000);
  assign period_end = step && ((dir_q && control_q[POS_MODE + 1]) ? at_zero : at_top);
  assign event_raw = period_end;
  assign event_out = event_raw && (post_q >= control_q[POS_POSTSCALE +: 4]);

  // time base counter
  always_comb
  begin
    pre_d = run ? (step ? 6'h00 : pre_q + 6'h01) : pre_q;
    count_d = count_q;
    dir_d = dir_q;
    post_d = post_q;
    if (event_raw)
    begin
      post_d = event_out ? 4'h0 : post_q + 4'h1;
    end
    if (step)
    begin
      unique case (mode)
        MODE_FREE, MODE_SINGLE:
        begin
          dir_d = 1'b0;
          count_d = at_top ? COUNT_RESET : count_q + 15'h0001;
        end
        MODE_UPDOWN, MODE_UPDOWN_DBL:
        begin
          if (!dir_q && at_top)
          begin
            dir_d = 1'b1;
            count_d = count_q - 15'h0001;
          end
          else if (dir_q && at_zero)
          begin
            dir_d = 1'b0;
            count_d = count_q + 15'h0001;
          end
          else
          begin
            count_d = dir_q ? count_q - 15'h0001 : count_q + 15'h0001;
          end
        end
      endcase
    end
    if (do_write && awaddr_q == OFF_COUNT)
    begin
      count_d = count_wr[14:0];
    end
  end

  // interrupt sources: time base event, and zero or top in double mode
  always_comb
  begin
    set_bits = '0;
    set_bits[ST_EVENT] = event_out;
    set_bits[ST_ZERO] = step && at_zero && dir_q && (mode == MODE_UPDOWN_DBL);
    set_bits[ST_TOP] = step && at_top && !dir_q && (mode == MODE_UPDOWN_DBL);
  end

  // registers written by software
  always_comb
  begin
    control_d = control_q;
    period_d = period_q;
    misc_d = misc_q;
    mask_d = mask_q;
    status_d = status_q;
    duty_d = duty_q;
    if (do_write)
    begin
      unique case (awaddr_q)
        OFF_CONTROL: control_d = merge16(control_q, wdata_q, wstrb_q) & 16'hA0FF;
        OFF_PERIOD: period_d = period_wr[14:0];
        OFF_DUTY1: duty_d[0] = merge16(duty_q[0], wdata_q, wstrb_q);
        OFF_DUTY2: duty_d[1] = merge16(duty_q[1], wdata_q, wstrb_q);
        OFF_DUTY3: duty_d[2] = merge16(duty_q[2], wdata_q, wstrb_q);
        OFF_DUTY4: duty_d[3] = merge16(duty_q[3], wdata_q, wstrb_q);
        OFF_MISC: misc_d = wstrb_q[0] ? wdata_q[1:0] : misc_q;
        OFF_STATUS: status_d = wstrb_q[0] ? status_q & ~wdata_q[N_STATUS-1:0] : status_q;
        OFF_MASK: mask_d = wstrb_q[0] ? wdata_q[N_STATUS-1:0] : mask_q;
        default: ;
      endcase
    end
    if (period_end && mode == MODE_SINGLE)
    begin
      control_d[BIT_RUN] = 1'b0;
    end
    status_d = status_d | set_bits;
  end

  // axi4-lite handshakes
  always_comb
  begin
    aw_d = aw_q;
    w_d = w_q;
    b_d = b_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bresp_d = bresp_q;
    if (s_axi_awvalid && !aw_q)
    begin
      aw_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_q)
    begin
      w_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (do_write)
    begin
      b_d = 1'b1;
      bresp_d = known(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
    end
    if (b_q && s_axi_bready)
    begin
      b_d = 1'b0;
      aw_d = 1'b0;
      w_d = 1'b0;
    end
    r_d = r_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_axi_arvalid && !r_q)
    begin
      r_d = 1'b1;
      rresp_d = known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_araddr)
        OFF_CONTROL: rdata_d = {16'h0000, control_q};
        OFF_COUNT: rdata_d = {16'h0000, dir_q, count_q};
        OFF_PERIOD: rdata_d = {17'h00000, period_q};
        OFF_DUTY1: rdata_d = {16'h0000, duty_q[0]};
        OFF_DUTY2: rdata_d = {16'h0000, duty_q[1]};
        OFF_DUTY3: rdata_d = {16'h0000, duty_q[2]};
        OFF_DUTY4: rdata_d = {16'h0000, duty_q[3]};
        OFF_MISC: rdata_d = {30'h00000000, misc_q};
        OFF_STATUS: rdata_d = {29'h00000000, status_q};
        OFF_MASK: rdata_d = {29'h00000000, mask_q};
        default: rdata_d = 32'h00000000;
      endcase
    end
    else if (r_q && s_axi_rready)
    begin
      r_d = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      control_q <= CONTROL_RESET;
      count_q <= COUNT_RESET;
      dir_q <= 1'b0;
      period_q <= PERIOD_RESET;
      misc_q <= MISC_RESET;
      status_q <= '0;
      mask_q <= '0;
      pre_q <= 6'h00;
      post_q <= 4'h0;
      for (int i = 0; i < N_GEN; i++)
      begin
        duty_q[i] <= 16'h0000;
      end
      aw_q <= 1'b0;
      w_q <= 1'b0;
      b_q <= 1'b0;
      r_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bresp_q <= RESP_OKAY;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
    end
    else
    begin
      control_q <= control_d;
      count_q <= count_d;
      dir_q <= dir_d;
      period_q <= period_d;
      misc_q <= misc_d;
      status_q <= status_d;
      mask_q <= mask_d;
      pre_q <= pre_d;
      post_q <= post_d;
      duty_q <= duty_d;
      aw_q <= aw_d;
      w_q <= w_d;
      b_q <= b_d;
      r_q <= r_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bresp_q <= bresp_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  assign tick.count_value = count_q;
  assign tick.boundary = period_end;

  genvar g;
  generate
    for (g = 0; g < N_GEN; g++)
    begin : gen_duty
      duty_gen u_duty (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick),
        .duty_new(duty_q[g]),
        .immediate(misc_q[BIT_IMMEDIATE]),
        .complement(misc_q[BIT_COMPLEMENT]),
        .high_out(high_out[g]),
        .low_out(low_out[g])
      );
    end
  endgenerate

  assign s_axi_awready = !aw_q;
  assign s_axi_wready = !w_q;
  assign s_axi_bvalid = b_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !r_q;
  assign s_axi_rvalid = r_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign irq = |(status_q & mask_q);
endmodule

// ===== common/pwm_tb_pkg.sv
// Purpose: constants and types shared by the pwm time base design
// Assumes: 32-bit axi4-lite register bus, 40 MHz aclk
// Notes: register offsets are byte addresses
package pwm_tb_pkg;
  localparam int ADDR_W = 6;
  localparam logic [ADDR_W-1:0] OFF_CONTROL = 6'h00;
  localparam logic [ADDR_W-1:0] OFF_COUNT = 6'h04;
  localparam logic [ADDR_W-1:0] OFF_PERIOD = 6'h08;
  localparam logic [ADDR_W-1:0] OFF_DUTY1 = 6'h0C;
  localparam logic [ADDR_W-1:0] OFF_DUTY2 = 6'h10;
  localparam logic [ADDR_W-1:0] OFF_DUTY3 = 6'h14;
  localparam logic [ADDR_W-1:0] OFF_DUTY4 = 6'h18;
  localparam logic [ADDR_W-1:0] OFF_MISC = 6'h1C;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 6'h20;
  localparam logic [ADDR_W-1:0] OFF_MASK = 6'h24;
  // control field positions
  localparam int BIT_RUN = 15;
  localparam int BIT_IDLE_HALT = 13;
  localparam int POS_POSTSCALE = 4;
  localparam int POS_PRESCALE = 2;
  localparam int POS_MODE = 0;
  localparam int BIT_DIR = 15;
  // misc register: bit0 immediate duty update, bit1 complementary outputs
  localparam int BIT_IMMEDIATE = 0;
  localparam int BIT_COMPLEMENT = 1;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [14:0] COUNT_RESET = 15'h0000;
  localparam logic [14:0] PERIOD_RESET = 15'h0000;
  localparam logic [1:0] MISC_RESET = 2'h2;
  localparam int N_STATUS = 3;
  localparam int ST_EVENT = 0;
  localparam int ST_ZERO = 1;
  localparam int ST_TOP = 2;
  localparam int N_GEN = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    MODE_FREE = 2'h0,
    MODE_SINGLE = 2'h1,
    MODE_UPDOWN = 2'h2,
    MODE_UPDOWN_DBL = 2'h3
  } count_mode_t;
endpackage

// ===== common/tick_if.sv
// Purpose: carries time base ticks from the counter to the duty generators
// Assumes: single clock domain
// Notes: boundary is a pulse of one aclk cycle, count_value carries the live count
`timescale 1ns/1ps
interface tick_if;
  logic [14:0] count_value;
  logic boundary;
  modport source (output count_value, output boundary);
  modport sink (input count_value, input boundary);
endinterface

// ===== design/duty_gen.sv
// Purpose: one duty-cycle generator with high and low outputs
// Assumes: counter and boundary arrive through tick_if
// Notes: duty value latched either at once or on the time base boundary
`timescale 1ns/1ps
module duty_gen
  import pwm_tb_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  tick_if.sink tick,
  input wire logic [15:0] duty_new,
  input wire logic immediate,
  input wire logic complement,
  output logic high_out,
  output logic low_out
);
  logic [15:0] duty_q, duty_d;
  logic high_q, high_d;
  logic low_q, low_d;

  always_comb
  begin
    duty_d = duty_q;
    if (immediate || tick.boundary)
    begin
      duty_d = duty_new;
    end
    high_d = ({1'b0, tick.count_value} < duty_q);
    low_d = complement ? !high_d : 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      duty_q <= 16'h0000;
      high_q <= 1'b0;
      low_q <= 1'b0;
    end
    else
    begin
      duty_q <= duty_d;
      high_q <= high_d;
      low_q <= low_d;
    end
  end

  assign high_out = high_q;
  assign low_out = low_q;
endmodule

// ===== testbench/pwm_time_base_sva.sv
// Purpose: bus and output checks at the pwm time base ports
// Assumes: one aclk domain, sync active-low reset
// Notes: attached by bind in the testbench top
`timescale 1ns/1ps
module pwm_time_base_sva
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] high_out,
  input wire logic [3:0] low_out
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_wr_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
    else $error("write not answered two cycles after capture");
  a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered next cycle");
  a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_r_released: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data still valid after handshake");
  a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_rdata_top: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  a_low_inverse: assert property (low_out != 4'h0 |-> low_out == ~high_out)
    else $error("low outputs not inverse of high");
endmodule

// ===== testbench/gate_driver_model.sv
// Purpose: power stage gate driver stand-in
// Assumes: outputs sampled on aclk
// Notes: counts shoot-through on all legs and high-side pulses of leg 0 only
`timescale 1ns/1ps
module gate_driver_model
(
  input wire logic aclk,
  input wire logic [3:0] high_out,
  input wire logic [3:0] low_out,
  output int overlap_cnt,
  output int pulse_cnt
);
  logic h_q = 1'b0;
  int ov_q = 0;
  int pl_q = 0;
  assign overlap_cnt = ov_q;
  assign pulse_cnt = pl_q;
  // both switches of one leg on would short the supply
  always @(posedge aclk)
  begin
    h_q <= high_out[0];
    if ((high_out & low_out) != 4'h0)
      ov_q <= ov_q + 1;
    if (high_out[0] && !h_q)
      pl_q <= pl_q + 1;
  end
endmodule

// ===== testbench/testbench.sv
// Purpose: register-level test of the pwm time base
// Assumes: 40 MHz aclk, sync active-low reset
// Notes: all waits bounded
`timescale 1ns/1ps
module testbench;
  import pwm_tb_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, cpu_idle = 1'b0, irq, dir_seen;
  logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata, rd_q;
  logic [3:0] s_axi_wstrb = 4'hF, high_out, low_out;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp_q;
  int error_cnt = 0, total_checks = 0, overlap_cnt, pulse_cnt;
  motor_pwm_time_base i_dut (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .cpu_idle(cpu_idle),
    .high_out(high_out),
    .low_out(low_out),
    .irq(irq)
  );
  gate_driver_model i_gates (
    .aclk(aclk),
    .high_out(high_out),
    .low_out(low_out),
    .overlap_cnt(overlap_cnt),
    .pulse_cnt(pulse_cnt)
  );
  always #12.5 aclk = ~aclk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic lost();
    error_cnt++;
    $display("BAD %0t bus wait ran out", $time);
    wrap_up();
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    logic aw, w, b;
    aw = 1'b1;
    w = 1'b1;
    b = 1'b1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b0;
    for (int n = 0; b; n++)
    begin
      if (n == 40)
        lost();
      @(posedge aclk);
      aw = aw && !s_axi_awready;
      w = w && !s_axi_wready;
      resp_q = s_axi_bresp;
      b = !(s_axi_bready && s_axi_bvalid);
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
      s_axi_bready <= b && s_axi_bvalid;
    end
  endtask
  task automatic rd(input logic [5:0] a);
    logic ar, r;
    ar = 1'b1;
    r = 1'b1;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b0;
    for (int n = 0; r; n++)
    begin
      if (n == 40)
        lost();
      @(posedge aclk);
      ar = ar && !s_axi_arready;
      rd_q = s_axi_rdata;
      resp_q = s_axi_rresp;
      r = !(s_axi_rready && s_axi_rvalid);
      s_axi_arvalid <= ar;
      s_axi_rready <= r && s_axi_rvalid;
    end
  endtask
  task automatic rchk(input logic [5:0] a, input logic [31:0] exp);
    rd(a);
    chk(rd_q, exp);
  endtask
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(OFF_CONTROL, 32'h00000000);
    rchk(OFF_MISC, 32'h00000002);
    wr(OFF_PERIOD, 16'hFFFF);
    rchk(OFF_PERIOD, 32'h00007FFF);
    wr(OFF_CONTROL, 16'hFFFF);
    rchk(OFF_CONTROL, 32'h0000A0FF);
    wr(OFF_CONTROL, 16'h0000);
    wr(OFF_COUNT, 16'h8005);
    repeat (20) @(posedge aclk);
    rchk(OFF_COUNT, 32'h00000005);
    rchk(6'h3C, 32'h00000000);
    chk(32'(resp_q), 32'(RESP_SLVERR));
    wr(6'h3C, 16'hFFFF);
    chk(32'(resp_q), 32'(RESP_SLVERR));
    // free running, period 3, event postscaled 1:4
    wr(OFF_PERIOD, 16'h0003);
    chk(32'(resp_q), 32'(RESP_OKAY));
    wr(OFF_COUNT, 16'h0000);
    wr(OFF_DUTY1, 16'h0002);
    wr(OFF_STATUS, 16'h0007);
    wr(OFF_CONTROL, 16'h8030);
    rchk(OFF_STATUS, 32'h00000000);
    repeat (20) @(posedge aclk);
    rchk(OFF_STATUS, 32'h00000001);
    chk(32'(irq), 32'h0);
    wr(OFF_MASK, 16'h0001);
    chk(32'(irq), 32'h1);
    wr(OFF_CONTROL, 16'h0000);
    wr(OFF_STATUS, 16'h0001);
    chk(32'(irq), 32'h0);
    chk(32'(pulse_cnt > 0), 32'h1);
    chk(32'(overlap_cnt), 32'h0);
    // stopped time base: boundary update holds the old duty, immediate takes it
    wr(OFF_COUNT, 16'h0005);
    wr(OFF_DUTY1, 16'h0010);
    repeat (4) @(posedge aclk);
    chk(32'(high_out[0]), 32'h0);
    wr(OFF_MISC, 16'h0003);
    repeat (2) @(posedge aclk);
    chk(32'(high_out[0]), 32'h1);
    chk(32'(low_out[0]), 32'h0);
    // prescale 1:64 over about 200 cycles
    wr(OFF_PERIOD, 16'h7FFF);
    wr(OFF_COUNT, 16'h0000);
    wr(OFF_CONTROL, 16'h800C);
    repeat (200) @(posedge aclk);
    wr(OFF_CONTROL, 16'h0000);
    rd(OFF_COUNT);
    chk(32'(rd_q >= 3 && rd_q <= 4), 32'h1);
    // idle halt on, then off
    wr(OFF_COUNT, 16'h0000);
    cpu_idle <= 1'b1;
    wr(OFF_CONTROL, 16'hA000);
    repeat (20) @(posedge aclk);
    rchk(OFF_COUNT, 32'h00000000);
    wr(OFF_CONTROL, 16'h8000);
    repeat (20) @(posedge aclk);
    rd(OFF_COUNT);
    chk(32'(rd_q != 0), 32'h1);
    cpu_idle <= 1'b0;
    // up/down without then with double-update interrupts
    wr(OFF_PERIOD, 16'h0003);
    wr(OFF_COUNT, 16'h0000);
    wr(OFF_STATUS, 16'h0007);
    wr(OFF_CONTROL, 16'h8002);
    dir_seen = 1'b0;
    repeat (8)
    begin
      rd(OFF_COUNT);
      dir_seen = dir_seen | rd_q[15];
      chk(32'(rd_q[14:0] <= 3), 32'h1);
    end
    chk(32'(dir_seen), 32'h1);
    rd(OFF_STATUS);
    chk(32'(rd_q[2:1]), 32'h0);
    wr(OFF_CONTROL, 16'h8003);
    repeat (20) @(posedge aclk);
    rd(OFF_STATUS);
    chk(32'(rd_q[2:1]), 32'h3);
    // single event clears run at period end
    wr(OFF_CONTROL, 16'h0000);
    wr(OFF_COUNT, 16'h0000);
    wr(OFF_CONTROL, 16'h8001);
    repeat (20) @(posedge aclk);
    rchk(OFF_CONTROL, 32'h00000001);
    rchk(OFF_COUNT, 32'h00000000);
    wrap_up();
  end
endmodule

bind motor_pwm_time_base pwm_time_base_sva i_sva (
  .aclk(aclk),
  .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .high_out(high_out),
  .low_out(low_out)
);
